// [trs_trigger_router.sv]
// Trigger router: selection registers, legality check and routed outputs.
`include "trs_regs.svh"

module trs_trigger_router (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [`TRS_ADDR_W-1:0] reg_addr,
  input trs_pkg::trs_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output trs_pkg::trs_word_t reg_rdata,
  input wire logic [`TRS_PIN_N-1:0] external_trigger_pin_input,
  input wire logic [`TRS_PERIPH_N-1:0] periph_src,
  output logic [7:0] external_trigger_output,
  output logic [2:0] converter_routine_trigger,
  output logic [1:0] dac_output_trigger,
  output logic [13:0] timer_break_input,
  output logic [2:0] can_time_tick,
  output logic temp_sensor_trigger,
  output logic encoder_emulation_trigger,
  output logic digital_filter_trigger,
  output logic [9:0] timer_external_trigger_input,
  output logic [16:0] timer_internal_trigger_14
);
  import trs_pkg::*;

  // ****************************************************************
  // Register table
  // ****************************************************************

  function automatic logic [1:0] reg_nout(input logic [5:0] r);
    if (r < `TRS_IDX_ADC0) begin
      return 2'd2;
    end else if (r == `TRS_IDX_T0BRK || r == `TRS_IDX_T7BRK) begin
      return 2'd3;
    end else begin
      return 2'd1;
    end
  endfunction

  function automatic trs_kind_e reg_kind(input logic [5:0] r);
    if (r >= `TRS_IDX_T0BRK && r < `TRS_IDX_CAN0) begin
      return TRS_KIND_BRK;
    end else if (r >= `TRS_IDX_ITI0) begin
      return TRS_KIND_ITI;
    end else begin
      return TRS_KIND_GEN;
    end
  endfunction

  // First output number of each register, outputs in register order.
  function automatic int reg_obase(input logic [5:0] r);
    if (r < `TRS_IDX_ADC0) begin
      return 2 * int'(r);
    end else if (r <= `TRS_IDX_T0BRK) begin
      return int'(r) + 4;
    end else if (r == `TRS_IDX_T7BRK) begin
      return int'(r) + 6;
    end else begin
      return int'(r) + 8;
    end
  endfunction

  function automatic logic is_adc(input logic [5:0] r);
    return r >= `TRS_IDX_ADC0 && r < `TRS_IDX_DAC0;
  endfunction

  // Codes owned by the timer behind each trigger 14 register: {lo, hi}.
  function automatic logic [15:0] iti_own(input logic [5:0] r);
    unique case (r)
      6'h23: return {8'h11, 8'h24};
      6'h24: return {8'h25, 8'h2a};
      6'h25: return {8'h2b, 8'h30};
      6'h26: return {8'h31, 8'h36};
      6'h27: return {8'h37, 8'h3c};
      6'h28: return {8'h3f, 8'h52};
      6'h29: return {8'h53, 8'h59};
      6'h2a: return {8'h64, 8'h69};
      6'h2b: return {8'h6a, 8'h6f};
      6'h2c: return {8'h70, 8'h75};
      6'h2d: return {8'h76, 8'h7b};
      6'h2e: return {8'h7c, 8'h82};
      6'h2f: return {8'h83, 8'h89};
      6'h30: return {8'h8a, 8'h90};
      6'h31: return {8'h91, 8'h97};
      6'h32: return {8'h98, 8'h9e};
      6'h33: return {8'h98, 8'h9e};
      default: return 16'h0000;
    endcase
  endfunction

  // ****************************************************************
  // Source code classes
  // ****************************************************************

  function automatic logic is_reserved(input trs_code_t c);
    return (c >= 8'h1b && c <= 8'h20) || (c >= 8'h49 && c <= 8'h4e) ||
           (c >= 8'h57 && c <= 8'h58) || (c >= 8'h5c && c <= 8'h5d) ||
           (c >= 8'h61 && c <= 8'h62) || (c >= 8'h80 && c <= 8'h81) ||
           (c >= 8'h87 && c <= 8'h88) || (c >= 8'h8e && c <= 8'h8f) ||
           (c >= 8'h95 && c <= 8'h96) || (c >= 8'h9c && c <= 8'h9d) ||
           (c > `TRS_CODE_LAST);
  endfunction

  function automatic logic is_brk(input trs_code_t c);
    return (c >= 8'h21 && c <= 8'h23) || (c >= 8'h4f && c <= 8'h51) ||
           c == 8'h59 || c == 8'h5e || c == 8'h63 || c == 8'h82 ||
           c == 8'h89 || c == 8'h90 || c == 8'h97 || c == 8'h9e;
  endfunction

  function automatic logic is_legal(input trs_code_t c,
                                    input logic [5:0] r);
    logic [15:0] own;
    logic other;
    own = iti_own(r);
    other = c == `TRS_CODE_LXTAL || c == `TRS_CODE_CMP0 ||
            c == `TRS_CODE_CMP1 || (c >= own[15:8] && c <= own[7:0]);
    if (is_reserved(c)) begin
      return 1'b0;
    end
    unique case (reg_kind(r))
      TRS_KIND_BRK: return is_brk(c);
      TRS_KIND_ITI: return !is_brk(c) && !other;
      TRS_KIND_GEN: return !is_brk(c);
      default: return 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // Pin synchroniser and source pool
  // ****************************************************************

  logic [`TRS_PIN_N-1:0] pin_s1_r;
  logic [`TRS_PIN_N-1:0] pin_s2_r;
  logic [`TRS_SRC_N-1:0] src_vec;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= external_trigger_pin_input;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Pins lose two cycles in the synchroniser; on-chip sources none.
  assign src_vec = {{`TRS_PAD_N{1'b0}}, periph_src, pin_s2_r,
                    1'b1, 1'b0};

  // ****************************************************************
  // Selection registers
  // ****************************************************************

  logic [5:0] idx;
  logic idx_ok;
  logic lock_r [`TRS_REG_N];
  trs_code_t fld_r [`TRS_REG_N][3];
  trs_word_t rd_word;
  trs_word_t rdata_r;

  assign idx = reg_addr[`TRS_IDX_LSB +: 6];
  assign idx_ok = idx < 6'(`TRS_REG_N);

  genvar gr, gs;
  generate
    for (gr = 0; gr < `TRS_REG_N; gr++) begin : g_reg
      logic we;
      assign we = reg_wr && idx_ok && idx == 6'(gr) &&
                  !lock_r[gr];
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          lock_r[gr] <= 1'b0;
        end else if (we) begin
          lock_r[gr] <= reg_wdata[`TRS_LOCK_BIT];
        end
      end
      for (gs = 0; gs < 3; gs++) begin : g_fld
        localparam trs_code_t RST =
          !is_adc(6'(gr)) ? `TRS_RST_FLD :
          (gs == 0) ? `TRS_RST_ADC_FLD0 :
          (gs == 1) ? `TRS_RST_ADC_FLD1 : `TRS_RST_FLD;
        if (gs < reg_nout(6'(gr))) begin : g_rw
          always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
              fld_r[gr][gs] <= RST;
            end else if (we) begin
              fld_r[gr][gs] <= reg_wdata[gs*8 +: 8];
            end
          end
        end else begin : g_ro
          // Reserved field: keeps its reset value whatever is written.
          always_ff @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
              fld_r[gr][gs] <= RST;
            end else begin
              fld_r[gr][gs] <= RST;
            end
          end
        end
      end
    end
  endgenerate

  // Only whole words are decoded; byte lanes are not honoured.
  assign rd_word = idx_ok ?
    {lock_r[idx], 7'h00, fld_r[idx][2], fld_r[idx][1], fld_r[idx][0]} :
    32'h0000_0000;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_word : 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_r;

  // ****************************************************************
  // Routed outputs
  // ****************************************************************

  logic [`TRS_OUT_N-1:0] trig_r;

  generate
    for (gr = 0; gr < `TRS_REG_N; gr++) begin : g_out
      for (gs = 0; gs < reg_nout(6'(gr)); gs++) begin : g_slot
        localparam int ON = reg_obase(6'(gr)) + gs;
        logic ok;
        logic lvl;
        assign ok = is_legal(fld_r[gr][gs], 6'(gr));
        assign lvl = ok ? src_vec[fld_r[gr][gs]] : 1'b0;
        always_ff @(posedge sys_clk or negedge arst_n) begin
          if (!arst_n) begin
            trig_r[ON] <= 1'b0;
          end else begin
            trig_r[ON] <= lvl;
          end
        end
      end
    end
  endgenerate

  assign external_trigger_output = trig_r[7:0];
  assign converter_routine_trigger = trig_r[10:8];
  assign dac_output_trigger = trig_r[12:11];
  assign timer_break_input = trig_r[26:13];
  assign can_time_tick = trig_r[29:27];
  assign temp_sensor_trigger = trig_r[30];
  assign encoder_emulation_trigger = trig_r[31];
  assign digital_filter_trigger = trig_r[32];
  assign timer_external_trigger_input = trig_r[42:33];
  assign timer_internal_trigger_14 = trig_r[59:43];

endmodule

// [trs_regs.svh]
// Offsets, field positions, reset values and source codes of the router.
`ifndef TRS_REGS_SVH
`define TRS_REGS_SVH
`define TRS_ADDR_W 8
`define TRS_REG_N 52
`define TRS_OUT_N 60
`define TRS_PIN_N 14
`define TRS_PERIPH_N 162
`define TRS_SRC_N 256
`define TRS_PAD_N 78
`define TRS_LOCK_BIT 31
`define TRS_FLD0_LSB 0
`define TRS_FLD1_LSB 8
`define TRS_FLD2_LSB 16
`define TRS_IDX_LSB 2
`define TRS_OFS_EXTOUT0 8'h00
`define TRS_OFS_EXTOUT1 8'h04
`define TRS_OFS_EXTOUT2 8'h08
`define TRS_OFS_EXTOUT3 8'h0c
`define TRS_OFS_ADC0 8'h10
`define TRS_OFS_ADC1 8'h14
`define TRS_OFS_ADC2 8'h18
`define TRS_IDX_EXTOUT0 6'h00
`define TRS_IDX_ADC0 6'h04
`define TRS_IDX_DAC0 6'h07
`define TRS_IDX_T0BRK 6'h09
`define TRS_IDX_T7BRK 6'h0a
`define TRS_IDX_BRK1 6'h0b
`define TRS_IDX_CAN0 6'h13
`define TRS_IDX_TEMP 6'h16
`define TRS_IDX_ENC 6'h17
`define TRS_IDX_FILT 6'h18
`define TRS_IDX_ETI0 6'h19
`define TRS_IDX_ITI0 6'h23
`define TRS_RST_FLD 8'h00
`define TRS_RST_ADC_FLD0 8'h13
`define TRS_RST_ADC_FLD1 8'h11
`define TRS_CODE_LOW 8'h00
`define TRS_CODE_HIGH 8'h01
`define TRS_CODE_LXTAL 8'h10
`define TRS_CODE_CMP0 8'hac
`define TRS_CODE_CMP1 8'had
`define TRS_CODE_LAST 8'hb1
`endif

// [trs_pkg.sv]
// Types shared by the trigger router.
package trs_pkg;
  typedef logic [31:0] trs_word_t;
  typedef logic [7:0] trs_code_t;
  typedef enum logic [1:0] {
    TRS_KIND_GEN,
    TRS_KIND_BRK,
    TRS_KIND_ITI
  } trs_kind_e;
endpackage

// [trs_trigger_router_chk.sv]
// Port checker of the trigger router, bound to the design.
`include "trs_regs.svh"
module trs_trigger_router_chk (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [`TRS_ADDR_W-1:0] reg_addr,
  input trs_pkg::trs_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input trs_pkg::trs_word_t reg_rdata,
  input wire logic [`TRS_PERIPH_N-1:0] periph_src,
  input wire logic [7:0] external_trigger_output,
  input wire logic [13:0] timer_break_input,
  input wire logic [16:0] timer_internal_trigger_14
);
  import trs_pkg::*;
  // ****************************************
  // Lock shadow, so frozen writes are skipped.
  // ****************************************
  logic [63:0] lk_r;
  wire [5:0] idx = reg_addr[7:2];
  wire [7:0] f0 = reg_wdata[7:0];
  wire brk0 = f0 inside {8'h21, 8'h22, 8'h23, 8'h4f, 8'h50, 8'h51, 8'h59,
    8'h5e, 8'h63, 8'h82, 8'h89, 8'h90, 8'h97, 8'h9e};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) lk_r <= '0;
    else if (reg_wr && reg_wdata[31]) lk_r[idx] <= 1'b1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr(logic [5:0] i);
    reg_wr && idx == i && !lk_r[i];
  endsequence
  AST_CODE_LOW: assert property (s_wr(6'h00) ##0 f0 == 8'h00 |-> ##2
    !external_trigger_output[0]) else $error("code low not low");
  AST_CODE_HIGH: assert property (s_wr(6'h00) ##0 reg_wdata[15:8] == 8'h01
    |-> ##2 external_trigger_output[1]) else $error("code high not high");
  AST_RSV_ZERO: assert property (s_wr(6'h00) ##0 f0 > 8'hb1 |-> ##2
    !external_trigger_output[0]) else $error("reserved code routed");
  AST_GEN_NO_BRK: assert property (s_wr(6'h00) ##0 brk0 |-> ##2
    !external_trigger_output[0]) else $error("break source routed");
  AST_BRK_ONLY: assert property (s_wr(6'h09) ##0 !brk0 |-> ##2
    !timer_break_input[0]) else $error("break output took other source");
  AST_ITI_REJECT: assert property (s_wr(6'h23) ##0 (brk0 || f0 inside
    {8'h10, 8'hac, 8'had, [8'h11:8'h24]}) |-> ##2
    !timer_internal_trigger_14[0]) else $error("trigger 14 took rejected code");
  AST_PASS_LEVEL: assert property (s_wr(6'h00) ##0 f0 == 8'h3f |-> ##2
    external_trigger_output[0] == $past(periph_src[47]))
    else $error("routed level differs from source");
  AST_LOCK_READ: assert property (reg_rd && lk_r[idx] && idx < 6'd52 |=>
    reg_rdata[31]) else $error("lock bit lost");
endmodule
bind trs_trigger_router trs_trigger_router_chk u_chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .periph_src(periph_src), .external_trigger_output(external_trigger_output),
  .timer_break_input(timer_break_input),
  .timer_internal_trigger_14(timer_internal_trigger_14));

// [trs_src_model.sv]
// Model of the peripherals and pins that feed the router.
module trs_src_model (
  input wire logic sys_clk,
  input wire logic load,
  input wire logic [31:0] rnd,
  output logic [161:0] periph_src = '0,
  output logic [13:0] pin_level = '0
);
  // Sources are levels that hold between loads, as timer outputs do.
  always @(posedge sys_clk) begin
    if (load) begin
      periph_src <= {rnd[1:0], rnd, ~rnd, rnd ^ 32'ha5c3, rnd[15:0],
        rnd[31:16], rnd};
      pin_level <= rnd[27:14];
    end
  end
endmodule

// [trs_trigger_router_test.sv]
// Self-checking bench of the trigger router.
`include "trs_regs.svh"
`define TRS_CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module trs_trigger_router_test;
  timeunit 1ns;
  timeprecision 1ps;
  import trs_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [`TRS_ADDR_W-1:0] reg_addr = '0;
  trs_word_t reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic load = 1'b0;
  logic [31:0] lfsr = 32'h7d89;
  trs_word_t reg_rdata;
  logic [`TRS_PERIPH_N-1:0] periph_src;
  logic [13:0] pins;
  logic [7:0] ext_o;
  logic [2:0] conv_o;
  logic [13:0] brk_o;
  logic [16:0] iti_o;
  logic [1:0] dac_o;
  logic [2:0] can_o;
  logic tmp_o;
  logic enc_o;
  logic flt_o;
  logic [9:0] eti_o;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  trs_word_t mdl [0:63];
  trs_trigger_router u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_trigger_pin_input(pins), .periph_src(periph_src),
    .external_trigger_output(ext_o), .converter_routine_trigger(conv_o),
    .dac_output_trigger(dac_o), .timer_break_input(brk_o),
    .can_time_tick(can_o), .temp_sensor_trigger(tmp_o),
    .encoder_emulation_trigger(enc_o), .digital_filter_trigger(flt_o),
    .timer_external_trigger_input(eti_o),
    .timer_internal_trigger_14(iti_o));
  trs_src_model u_src (.sys_clk(sys_clk), .load(load), .rnd(lfsr),
    .periph_src(periph_src), .pin_level(pins));
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ****************************************
  // Reference model of routing and registers.
  // ****************************************
  function logic exp_out(int kind, logic [7:0] c, logic [7:0] lo,
    logic [7:0] hi);
    logic brk;
    logic ok;
    brk = c inside {8'h21, 8'h22, 8'h23, 8'h4f, 8'h50, 8'h51, 8'h59, 8'h5e,
      8'h63, 8'h82, 8'h89, 8'h90, 8'h97, 8'h9e};
    ok = !(c inside {[8'h1b:8'h20], [8'h49:8'h4e], [8'h57:8'h58],
      [8'h5c:8'h5d], [8'h61:8'h62], [8'h80:8'h81], [8'h87:8'h88],
      [8'h8e:8'h8f], [8'h95:8'h96], [8'h9c:8'h9d], [8'hb2:8'hff]});
    ok = ok && (kind == 1 ? brk : !brk);
    if (kind == 2 && (c inside {8'h10, 8'hac, 8'had, [lo:hi]})) ok = 1'b0;
    if (!ok || c == 8'h00) return 1'b0;
    if (c == 8'h01) return 1'b1;
    if (c < 8'h10) return pins[c - 8'h02];
    return periph_src[c - 8'h10];
  endfunction
  task mdl_reset();
    foreach (mdl[i]) mdl[i] = (i >= 4 && i <= 6) ? 32'h0000_1113 : '0;
  endtask
  // Whole words only; the model keeps a locked word frozen.
  task wr(int i, trs_word_t w);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= 8'(i * 4);
    reg_wdata <= w;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (i < 52 && !mdl[i][31]) mdl[i] = w;
  endtask
  task rd(int i);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= 8'(i * 4);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `TRS_CHK("reg_rdata", mdl[i], reg_rdata)
  endtask
  task check_outs();
    `TRS_CHK("ext0", exp_out(0, mdl[0][7:0], 0, 0), ext_o[0])
    `TRS_CHK("ext1", exp_out(0, mdl[0][15:8], 0, 0), ext_o[1])
    `TRS_CHK("conv0", exp_out(0, mdl[4][7:0], 0, 0), conv_o[0])
    for (int k = 1; k < 3; k++)
      `TRS_CHK("conv", exp_out(0, mdl[4+k][7:0], 0, 0), conv_o[k])
    `TRS_CHK("dac0", exp_out(0, mdl[7][7:0], 0, 0), dac_o[0])
    `TRS_CHK("dac1", exp_out(0, mdl[8][7:0], 0, 0), dac_o[1])
    for (int k = 0; k < 3; k++)
      `TRS_CHK("can", exp_out(0, mdl[19+k][7:0], 0, 0), can_o[k])
    `TRS_CHK("temp", exp_out(0, mdl[22][7:0], 0, 0), tmp_o)
    `TRS_CHK("enc", exp_out(0, mdl[23][7:0], 0, 0), enc_o)
    `TRS_CHK("filt", exp_out(0, mdl[24][7:0], 0, 0), flt_o)
    `TRS_CHK("eti0", exp_out(0, mdl[25][7:0], 0, 0), eti_o[0])
    for (int k = 0; k < 3; k++)
      `TRS_CHK("brk", exp_out(1, mdl[9][8*k +: 8], 0, 0), brk_o[k])
    `TRS_CHK("iti0", exp_out(2, mdl[35][7:0], 8'h11, 8'h24), iti_o[0])
    `TRS_CHK("iti5", exp_out(2, mdl[40][7:0], 8'h3f, 8'h52), iti_o[5])
  endtask
  task report_and_stop();
    if (bad_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    mdl_reset();
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 53; i++) rd(i);
    for (int c = 0; c < 256; c++) begin
      wr(0, {16'h0, 8'(c + 1), 8'(c)});
      wr(9, {8'h0, 8'(c + 2), 8'(c + 1), 8'(c)});
      wr(35, {24'h0, 8'(c)});
      wr(40, {24'h0, 8'(255 - c)});
      wr(7, {24'h0, 8'(c)});
      wr(25, {24'h0, 8'(255 - c)});
      repeat (3) begin
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        @(posedge sys_clk);
        load <= 1'b1;
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check_outs();
      end
    end
    rd(9);
    wr(0, 32'h8000_0001);
    @(negedge sys_clk);
    `TRS_CHK("ext0 before", 1'b0, ext_o[0])
    @(negedge sys_clk);
    `TRS_CHK("ext0 after", 1'b1, ext_o[0])
    wr(0, 32'h0000_0100);
    rd(0);
    check_outs();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    mdl_reset();
    rd(0);
    rd(4);
    check_outs();
    report_and_stop();
  end
endmodule
